// File: dv/oag_mem_model.sv
/*
 * Behavioural program and data memory for the address generator.
 * Assumes the bench loads bytes into mem and clears n_rd before each run.
 */
`timescale 1ns/1ps

module oag_mem_model (
    input  wire logic        sys_clk_in,
    input  wire logic        mem_rd_in,
    input  wire logic [15:0] mem_addr_in,
    output logic      [7:0]  mem_rdata_out
);
    logic [7:0]  mem      [0:65535];
    logic [15:0] log_addr [0:3];
    int          n_rd = 0;

    initial mem_rdata_out = 8'h00;

    // Fixed one-cycle answer; toggling otherwise so stale data cannot match
    always @(posedge sys_clk_in) begin
        if (mem_rd_in) begin
            mem_rdata_out <= mem[mem_addr_in];
            if (n_rd < 4) log_addr[n_rd] <= mem_addr_in;
            n_rd <= n_rd + 1;
        end else begin
            mem_rdata_out <= ~mem_rdata_out;
        end
    end
endmodule // oag_mem_model

// File: dv/operand_address_generator_tb.sv
/*
 * Self-checking bench of the operand address generator.
 * Assumes oag_mem_model answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps

module operand_address_generator_tb;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               start_in = 1'b0;
    logic               pfx_valid_in = 1'b0;
    logic [7:0]         prefix_in = 8'h00;
    logic               short_only_in = 1'b0;
    oag_pkg::oag_mode_e mode_in = oag_pkg::M_INH;
    logic [15:0]        pc = 16'h10f0;
    logic [7:0]         idx_x = 8'hff;
    logic [7:0]         idx_y = 8'h81;
    logic [7:0]         rdata;
    logic               rd;
    logic [15:0]        addr;
    logic               busy;
    logic               done;
    oag_pkg::oag_res_s  res;
    int                 miscompares = 0;
    int                 checked = 0;
    int                 cyc;

    initial forever #12.5 clk = ~clk;

    oag_addr_gen u_dut (.sys_clk_in(clk), .rst_in(rst), .start_in(start_in), .pc_in(pc),
        .pfx_valid_in(pfx_valid_in), .prefix_in(prefix_in), .mode_in(mode_in),
        .short_only_in(short_only_in), .idx_x_in(idx_x), .idx_y_in(idx_y),
        .mem_rdata_in(rdata), .mem_rd_out(rd), .mem_addr_out(addr), .busy_out(busy),
        .done_out(done), .res_out(res));

    oag_mem_model u_mem (.sys_clk_in(clk), .mem_rd_in(rd), .mem_addr_in(addr),
        .mem_rdata_out(rdata));

    task automatic summarize();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp16({8'h00, got}, {8'h00, exp});
    endtask

    task automatic put(input logic [15:0] a, input logic [7:0] v);
        u_mem.mem[a] = v;
    endtask

    // One request; cyc holds cycles from the start cycle to done
    task automatic run(input oag_pkg::oag_mode_e m, input logic [7:0] pf, input logic so);
        u_mem.n_rd = 0;
        mode_in = m;
        pfx_valid_in = (pf != 8'h00);
        prefix_in = pf;
        short_only_in = so;
        start_in = 1'b1;
        @(posedge clk);
        #2 start_in = 1'b0;
        cmp8({7'h00, busy}, 8'h01);
        cyc = 1;
        while (done !== 1'b1 && cyc < 20) begin
            @(posedge clk);
            #2 cyc++;
        end
        if (cyc >= 20) begin
            miscompares++;
            summarize();
        end
        cmp8({7'h00, busy}, 8'h00);
    endtask

    task automatic t_inh();
        run(oag_pkg::M_INH, 8'h00, 1'b0);
        cmp8(8'(res.len), 8'h01);
        cmp8(8'(cyc), 8'h02);
        cmp8(8'(u_mem.n_rd), 8'h00);
        run(oag_pkg::M_INH, 8'h90, 1'b0);
        cmp8(8'(res.len), 8'h02);
        run(oag_pkg::M_INH, 8'h33, 1'b0);
        cmp8(8'(res.err), 8'h01);
        cmp8(8'(u_mem.n_rd), 8'h00);
        $display("t_inh end");
    endtask

    task automatic t_dir();
        put(pc + 16'h0001, 8'hc3);
        run(oag_pkg::M_IMM, 8'h00, 1'b0);
        cmp8(res.opnd, 8'hc3);
        cmp8(8'(cyc), 8'h04);
        put(pc + 16'h0001, 8'h9e);
        put(pc + 16'h0002, 8'h47);
        run(oag_pkg::M_DIR_S, 8'h00, 1'b1);
        cmp16(res.ea, 16'h009e);
        cmp8(8'(res.err), 8'h00);
        run(oag_pkg::M_DIR_L, 8'h00, 1'b0);
        cmp16(res.ea, 16'h9e47);
        cmp16(u_mem.log_addr[1], pc + 16'h0002);
        cmp8(8'(res.len), 8'h03);
        run(oag_pkg::M_DIR_L, 8'h00, 1'b1);
        cmp8(8'(res.err), 8'h01);
        $display("t_dir end");
    endtask

    task automatic t_idx();
        run(oag_pkg::M_IDX0, 8'h00, 1'b0);
        cmp16(res.ea, 16'h00ff);
        cmp8(8'(res.len), 8'h01);
        run(oag_pkg::M_IDX0, 8'h90, 1'b0);
        cmp16(res.ea, 16'h0081);
        cmp8(8'(res.len), 8'h02);
        put(pc + 16'h0001, 8'hff);
        put(pc + 16'h0002, 8'hff);
        run(oag_pkg::M_IDX_S, 8'h00, 1'b0);
        cmp16(res.ea, 16'h01fe);
        run(oag_pkg::M_IDX_L, 8'h00, 1'b0);
        cmp16(res.ea, 16'h00fe);
        idx_x = 8'h3c;
        run(oag_pkg::M_IDX0, 8'h00, 1'b0);
        cmp16(res.ea, 16'h003c);
        idx_x = 8'hff;
        $display("t_idx end");
    endtask

    task automatic t_ind();
        put(pc + 16'h0001, 8'hfe);
        put(16'h00fe, 8'h12);
        put(16'h00ff, 8'h34);
        run(oag_pkg::M_DIR_S, 8'h92, 1'b0);
        cmp16(res.ea, 16'h0012);
        cmp8(8'(res.len), 8'h03);
        run(oag_pkg::M_DIR_L, 8'h92, 1'b0);
        cmp16(res.ea, 16'h1234);
        cmp8(8'(cyc), 8'h08);
        run(oag_pkg::M_IDX_S, 8'h92, 1'b0);
        cmp16(res.ea, 16'h0111);
        run(oag_pkg::M_IDX_S, 8'h91, 1'b0);
        cmp16(res.ea, 16'h0093);
        run(oag_pkg::M_IDX_L, 8'h92, 1'b0);
        cmp16(res.ea, 16'h1333);
        cmp8(8'(res.mode), 8'(oag_pkg::M_IIX_L));
        $display("t_ind end");
    endtask

    task automatic t_rel();
        put(pc + 16'h0001, 8'h80);
        run(oag_pkg::M_REL, 8'h00, 1'b0);
        cmp16(res.tgt, 16'h1072);
        put(pc + 16'h0001, 8'hfe);
        put(pc + 16'h0002, 8'h05);
        put(16'h00fe, 8'h7f);
        run(oag_pkg::M_REL, 8'h92, 1'b0);
        cmp16(res.tgt, 16'h1171);
        run(oag_pkg::M_BTJ, 8'h00, 1'b0);
        cmp16(res.ea, 16'h00fe);
        cmp16(res.tgt, 16'h10f8);
        run(oag_pkg::M_BTJ, 8'h92, 1'b0);
        cmp16(res.ea, 16'h007f);
        cmp16(u_mem.log_addr[2], 16'h00fe);
        cmp8(8'(res.len), 8'h04);
        cmp16(res.tgt, 16'h10f8);
        $display("t_rel end");
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #2 rst = 1'b0;
        t_inh();
        t_dir();
        t_idx();
        t_ind();
        t_rel();
        summarize();
    end
endmodule // operand_address_generator_tb

// File: verilog/oag_addr_gen.sv
/*
 * Operand address generator: sequences operand and pointer byte reads
 * for one instruction and returns the effective address, immediate
 * operand, relative target and length.
 * Assumes memory returns read data in the cycle after mem_rd_out.
 */
`timescale 1ns/1ps
`include "oag_map.svh"

// Notes on behaviour
// - Inherent: one byte, no operand fetch
// - Immediate: second byte is the operand
// - Short direct: one byte, page zero
// - Long direct: two address bytes, full space
// - Memory-modify instructions allow short forms only
// - No-offset indexed: address is the index
// - No-offset indexed with Y adds a byte
// - Short indexed: offset plus index, to 1FE
// - Long indexed: word offset plus index
// - Short indirect: byte pointer from page zero
// - Long indirect: word pointer from page zero
// - Indirect indexed: pointer plus index
// - Short pointer to 1FE, long full space
// - Other classes accept long and short
// - Relative target adds sign-extended offset
// - Relative base is the next instruction
// - Relative offset direct or from page zero
// - Prefix 90 selects Y index
// - Prefix 92 selects indirect forms
// - Prefix 91 selects Y indirect indexed
module oag_addr_gen (
    input  wire logic               sys_clk_in,
    input  wire logic               rst_in,
    input  wire logic               start_in,
    input  wire logic [15:0]        pc_in,
    input  wire logic               pfx_valid_in,
    input  wire logic [7:0]         prefix_in,
    input  wire oag_pkg::oag_mode_e mode_in,
    input  wire logic               short_only_in,
    input  wire logic [7:0]         idx_x_in,
    input  wire logic [7:0]         idx_y_in,
    input  wire logic [7:0]         mem_rdata_in,
    output logic                    mem_rd_out,
    output logic [15:0]             mem_addr_out,
    output logic                    busy_out,
    output logic                    done_out,
    output oag_pkg::oag_res_s       res_out
);

    oag_pkg::oag_state_e state_reg;
    oag_pkg::oag_dec_s   dec_now;
    oag_pkg::oag_dec_s   dec_reg;
    logic [15:0]         pc_reg;
    logic [7:0]          idx_reg;
    logic [7:0]          opr_reg [2];
    logic [7:0]          ptr_reg [2];
    logic [1:0]          cnt_reg;
    logic                ptr_phase_reg;
    logic [15:0]         pc_next;
    logic [15:0]         ea_calc;
    logic [15:0]         tgt_calc;
    logic                accept;
    logic                opr_last;
    logic                to_ptr;
    logic                more;
    logic [7:0]          ptr_loc;
    logic [2:0]          rd_cnt_reg;

    oag_mode_decode u_dec (
        .pfx_valid_in  (pfx_valid_in),
        .prefix_in     (prefix_in),
        .mode_in       (mode_in),
        .short_only_in (short_only_in),
        .dec_out       (dec_now)
    );

    oag_ea_calc u_calc (
        .mode_in    (dec_reg.mode),
        .opr0_in    (opr_reg[0]),
        .opr1_in    (opr_reg[1]),
        .ptr0_in    (ptr_reg[0]),
        .ptr1_in    (ptr_reg[1]),
        .idx_in     (idx_reg),
        .pc_next_in (pc_next),
        .ea_out     (ea_calc),
        .tgt_out    (tgt_calc)
    );

    // Requests that arrive while busy are ignored, not queued
    assign accept   = (state_reg == oag_pkg::ST_IDLE) && start_in;
    assign pc_next  = pc_reg + 16'h0001 + {14'h0000, dec_reg.nopr};
    assign opr_last = (cnt_reg == dec_reg.nopr - 2'h1);
    assign to_ptr   = !ptr_phase_reg && opr_last && (dec_reg.nptr != 2'h0);
    assign more     = ptr_phase_reg ? (cnt_reg != dec_reg.nptr - 2'h1)
                                    : (!opr_last || (dec_reg.nptr != 2'h0));
    // Pointer location is always the first operand byte
    assign ptr_loc  = (cnt_reg == 2'h0) ? mem_rdata_in : opr_reg[0];

    // no fetch when no operand bytes
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_reg <= oag_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                oag_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_reg <= (dec_now.nopr != 2'h0) ? oag_pkg::ST_RD
                                                            : oag_pkg::ST_CALC;
                    end
                end
                oag_pkg::ST_RD:   state_reg <= oag_pkg::ST_CAP;
                oag_pkg::ST_CAP:  state_reg <= more ? oag_pkg::ST_RD : oag_pkg::ST_CALC;
                oag_pkg::ST_CALC: state_reg <= oag_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pc_reg  <= `OAG_ADDR_RST;
            idx_reg <= `OAG_BYTE_RST;
            dec_reg <= '0;
        end else if (accept) begin
            pc_reg  <= pc_in;
            dec_reg <= dec_now;
            idx_reg <= dec_now.use_y ? idx_y_in : idx_x_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cnt_reg       <= 2'h0;
            ptr_phase_reg <= 1'b0;
        end else if (accept) begin
            cnt_reg       <= 2'h0;
            ptr_phase_reg <= 1'b0;
        end else if ((state_reg == oag_pkg::ST_CAP) && more) begin
            cnt_reg       <= to_ptr ? 2'h0 : cnt_reg + 2'h1;
            ptr_phase_reg <= ptr_phase_reg | to_ptr;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_byte
        always_ff @(posedge sys_clk_in) begin
            if (rst_in || accept) begin
                opr_reg[g] <= `OAG_BYTE_RST;
                ptr_reg[g] <= `OAG_BYTE_RST;
            end else if ((state_reg == oag_pkg::ST_CAP) && (cnt_reg == 2'(g))) begin
                if (ptr_phase_reg) begin
                    ptr_reg[g] <= mem_rdata_in;
                end else begin
                    opr_reg[g] <= mem_rdata_in;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mem_rd_out   <= 1'b0;
            mem_addr_out <= `OAG_ADDR_RST;
        end else begin
            mem_rd_out <= 1'b0;
            if (accept && (dec_now.nopr != 2'h0)) begin
                mem_rd_out   <= 1'b1;
                mem_addr_out <= pc_in + 16'h0001;
            end else if ((state_reg == oag_pkg::ST_CAP) && more) begin
                mem_rd_out <= 1'b1;
                if (to_ptr) begin
                    mem_addr_out <= {`OAG_ZPAGE, ptr_loc};
                end else if (ptr_phase_reg) begin
                    // Second pointer byte wraps inside page zero
                    mem_addr_out <= {`OAG_ZPAGE, opr_reg[0] + 8'h01};
                end else begin
                    mem_addr_out <= pc_reg + 16'h0002 + {14'h0000, cnt_reg};
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
        end else if (accept) begin
            busy_out <= 1'b1;
        end else if (state_reg == oag_pkg::ST_CALC) begin
            busy_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
            res_out  <= '0;
        end else begin
            done_out <= (state_reg == oag_pkg::ST_CALC);
            if (state_reg == oag_pkg::ST_CALC) begin
                res_out.ea   <= ea_calc;
                res_out.tgt  <= tgt_calc;
                res_out.opnd <= (dec_reg.mode == oag_pkg::M_IMM) ? opr_reg[0]
                                                                 : `OAG_BYTE_RST;
                res_out.len  <= dec_reg.len;
                res_out.mode <= dec_reg.mode;
                res_out.err  <= dec_reg.ill;
            end
        end
    end

    // Read count per instruction, used by the checks below
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || accept) begin
            rd_cnt_reg <= 3'h0;
        end else if (mem_rd_out) begin
            rd_cnt_reg <= rd_cnt_reg + 3'h1;
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_ok(oag_pkg::oag_mode_e m);
        done_out && !res_out.err && (res_out.mode == m);
    endsequence

    property p_inh;
        s_ok(oag_pkg::M_INH) |-> (rd_cnt_reg == 3'h0);
    endproperty
    a_inh: assert property (p_inh) else $error("inherent fetched bytes");

    property p_imm;
        s_ok(oag_pkg::M_IMM) |-> (rd_cnt_reg == 3'h1) &&
            (res_out.opnd == $past(mem_rdata_in, 2));
    endproperty
    a_imm: assert property (p_imm) else $error("immediate operand wrong");

    property p_dir_s;
        s_ok(oag_pkg::M_DIR_S) |->
            (res_out.ea == {`OAG_ZPAGE, $past(mem_rdata_in, 2)});
    endproperty
    a_dir_s: assert property (p_dir_s) else $error("short direct wrong");

    property p_dir_l;
        s_ok(oag_pkg::M_DIR_L) |-> (rd_cnt_reg == 3'h2);
    endproperty
    a_dir_l: assert property (p_dir_l) else $error("long direct count");

    property p_short_only;
        accept && short_only_in && !pfx_valid_in && (mode_in == oag_pkg::M_DIR_L)
            |-> ##2 done_out && res_out.err;
    endproperty
    a_short_only: assert property (p_short_only) else $error("long form accepted");

    property p_idx0;
        s_ok(oag_pkg::M_IDX0) |-> (res_out.ea == {`OAG_ZPAGE, idx_reg}) &&
            (rd_cnt_reg == 3'h0);
    endproperty
    a_idx0: assert property (p_idx0) else $error("no-offset index wrong");

    property p_idx0_len;
        s_ok(oag_pkg::M_IDX0) |-> (res_out.len == (dec_reg.use_y ? 3'h2 : 3'h1));
    endproperty
    a_idx0_len: assert property (p_idx0_len) else $error("indexed length");

    property p_idx_s;
        s_ok(oag_pkg::M_IDX_S) |-> (res_out.ea <= `OAG_IDX_S_TOP) &&
            (res_out.ea == {`OAG_ZPAGE, $past(mem_rdata_in, 2)} + {`OAG_ZPAGE, idx_reg});
    endproperty
    a_idx_s: assert property (p_idx_s) else $error("short indexed sum");

    property p_ind_s;
        s_ok(oag_pkg::M_IND_S) |-> (rd_cnt_reg == 3'h2) &&
            (res_out.ea == {`OAG_ZPAGE, $past(mem_rdata_in, 2)});
    endproperty
    a_ind_s: assert property (p_ind_s) else $error("short indirect wrong");

    property p_ind_l;
        s_ok(oag_pkg::M_IND_L) |-> (rd_cnt_reg == 3'h3);
    endproperty
    a_ind_l: assert property (p_ind_l) else $error("long indirect count");

    property p_zpage;
        mem_rd_out && ptr_phase_reg |-> (mem_addr_out[15:8] == `OAG_ZPAGE);
    endproperty
    a_zpage: assert property (p_zpage) else $error("pointer off page zero");

    property p_rel;
        s_ok(oag_pkg::M_REL) |->
            (res_out.tgt == pc_reg + 16'h0002 +
                {{8{$past(mem_rdata_in[7], 2)}}, $past(mem_rdata_in, 2)});
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");

    property p_rel_base;
        s_ok(oag_pkg::M_REL) |-> (pc_next == pc_reg + 16'h0002);
    endproperty
    a_rel_base: assert property (p_rel_base) else $error("relative base wrong");

    property p_msb_first;
        s_ok(oag_pkg::M_DIR_L) |-> (res_out.ea[15:8] == $past(mem_rdata_in, 4));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("byte order wrong");

    property p_latency;
        accept |-> ##[2:8] done_out;
    endproperty
    a_latency: assert property (p_latency) else $error("no result in time");

    c_iix_l: cover property (s_ok(oag_pkg::M_IIX_L));
    c_btj_i: cover property (s_ok(oag_pkg::M_BTJ_I));
    c_rel_i: cover property (s_ok(oag_pkg::M_REL_I));
    c_err:   cover property (done_out && res_out.err);

endmodule // oag_addr_gen

// File: verilog/oag_ea_calc.sv
/*
 * Combinational effective address and relative target adder.
 * Assumes operand and pointer bytes are held stable by the sequencer.
 */
`timescale 1ns/1ps
`include "oag_map.svh"

module oag_ea_calc (
    input  wire oag_pkg::oag_mode_e mode_in,
    input  wire logic [7:0]        opr0_in,
    input  wire logic [7:0]        opr1_in,
    input  wire logic [7:0]        ptr0_in,
    input  wire logic [7:0]        ptr1_in,
    input  wire logic [7:0]        idx_in,
    input  wire logic [15:0]       pc_next_in,
    output logic      [15:0]       ea_out,
    output logic      [15:0]       tgt_out
);

    logic [15:0] base;
    logic        add_idx;
    logic [7:0]  offs;

    always_comb begin
        base    = `OAG_ADDR_RST;
        add_idx = 1'b0;
        offs    = `OAG_BYTE_RST;
        // first byte is the high byte
        unique case (mode_in)
            oag_pkg::M_DIR_S, oag_pkg::M_BIT: base = {`OAG_ZPAGE, opr0_in};
            oag_pkg::M_BTJ: begin
                base = {`OAG_ZPAGE, opr0_in};
                offs = opr1_in;
            end
            oag_pkg::M_DIR_L: base = {opr0_in, opr1_in};
            oag_pkg::M_IDX0:  add_idx = 1'b1;
            oag_pkg::M_IDX_S: begin
                base    = {`OAG_ZPAGE, opr0_in};
                add_idx = 1'b1;
            end
            oag_pkg::M_IDX_L: begin
                base    = {opr0_in, opr1_in};
                add_idx = 1'b1;
            end
            oag_pkg::M_IND_S, oag_pkg::M_BIT_I: base = {`OAG_ZPAGE, ptr0_in};
            oag_pkg::M_BTJ_I: begin
                base = {`OAG_ZPAGE, ptr0_in};
                offs = opr1_in;
            end
            oag_pkg::M_IND_L: base = {ptr0_in, ptr1_in};
            oag_pkg::M_IIX_S: begin
                base    = {`OAG_ZPAGE, ptr0_in};
                add_idx = 1'b1;
            end
            oag_pkg::M_IIX_L: begin
                base    = {ptr0_in, ptr1_in};
                add_idx = 1'b1;
            end
            oag_pkg::M_REL:   offs = opr0_in;
            oag_pkg::M_REL_I: offs = ptr0_in;
            default:          base = `OAG_ADDR_RST;
        endcase
        // unsigned sum, wraps at 16 bits
        ea_out  = base + (add_idx ? {`OAG_ZPAGE, idx_in} : `OAG_ADDR_RST);
        tgt_out = pc_next_in + {{8{offs[7]}}, offs};
    end

endmodule // oag_ea_calc

// File: verilog/oag_map.svh
/*
 * Constants of the operand address generator: prefix byte values,
 * page-zero high byte, address bounds and reset values.
 * Assumes it is included by bare name from the address generator, adder and decoder modules.
 */
`ifndef OAG_MAP_SVH
`define OAG_MAP_SVH

`define OAG_PFX_Y      8'h90
`define OAG_PFX_IND    8'h92
`define OAG_PFX_YIND   8'h91
`define OAG_ZPAGE      8'h00
`define OAG_IDX_S_TOP  16'h01fe
`define OAG_ADDR_RST   16'h0000
`define OAG_BYTE_RST   8'h00
`define OAG_LEN_RST    3'h0

`endif

// File: verilog/oag_mode_decode.sv
/*
 * Combinational mode resolver: applies a prefix byte to the base mode,
 * flags illegal pairs and gives operand and pointer byte counts.
 * Assumes the core supplies the X-form base mode of the opcode.
 */
`timescale 1ns/1ps
`include "oag_map.svh"

module oag_mode_decode (
    input  wire logic              pfx_valid_in,
    input  wire logic [7:0]        prefix_in,
    input  wire oag_pkg::oag_mode_e mode_in,
    input  wire logic              short_only_in,
    output oag_pkg::oag_dec_s      dec_out
);

    always_comb begin
        dec_out      = '0;
        dec_out.mode = mode_in;
        // Indirect forms only exist through a prefix
        dec_out.ill  = mode_in inside {oag_pkg::M_IND_S, oag_pkg::M_IND_L,
                                       oag_pkg::M_IIX_S, oag_pkg::M_IIX_L,
                                       oag_pkg::M_REL_I, oag_pkg::M_BIT_I,
                                       oag_pkg::M_BTJ_I};
        if (pfx_valid_in) begin
            unique case (prefix_in)
                `OAG_PFX_Y: begin
                    dec_out.use_y = 1'b1;
                    if (!(mode_in inside {oag_pkg::M_INH, oag_pkg::M_IMM,
                                          oag_pkg::M_DIR_S, oag_pkg::M_DIR_L,
                                          oag_pkg::M_IDX0, oag_pkg::M_IDX_S,
                                          oag_pkg::M_IDX_L})) begin
                        dec_out.ill = 1'b1;
                    end
                end
                `OAG_PFX_IND: begin
                    unique case (mode_in)
                        oag_pkg::M_DIR_S: dec_out.mode = oag_pkg::M_IND_S;
                        oag_pkg::M_DIR_L: dec_out.mode = oag_pkg::M_IND_L;
                        oag_pkg::M_IDX_S: dec_out.mode = oag_pkg::M_IIX_S;
                        oag_pkg::M_IDX_L: dec_out.mode = oag_pkg::M_IIX_L;
                        oag_pkg::M_REL:   dec_out.mode = oag_pkg::M_REL_I;
                        oag_pkg::M_BIT:   dec_out.mode = oag_pkg::M_BIT_I;
                        oag_pkg::M_BTJ:   dec_out.mode = oag_pkg::M_BTJ_I;
                        default:          dec_out.ill  = 1'b1;
                    endcase
                end
                `OAG_PFX_YIND: begin
                    dec_out.use_y = 1'b1;
                    unique case (mode_in)
                        oag_pkg::M_IDX_S: dec_out.mode = oag_pkg::M_IIX_S;
                        oag_pkg::M_IDX_L: dec_out.mode = oag_pkg::M_IIX_L;
                        default:          dec_out.ill  = 1'b1;
                    endcase
                end
                default: dec_out.ill = 1'b1;
            endcase
        end
        if (short_only_in && dec_out.mode inside {oag_pkg::M_DIR_L, oag_pkg::M_IDX_L,
                                                  oag_pkg::M_IND_L, oag_pkg::M_IIX_L}) begin
            dec_out.ill = 1'b1;
        end
        unique case (dec_out.mode)
            oag_pkg::M_INH, oag_pkg::M_IDX0:  dec_out.nopr = 2'h0;
            oag_pkg::M_DIR_L, oag_pkg::M_IDX_L,
            oag_pkg::M_BTJ, oag_pkg::M_BTJ_I: dec_out.nopr = 2'h2;
            default:                          dec_out.nopr = 2'h1;
        endcase
        unique case (dec_out.mode)
            oag_pkg::M_IND_L, oag_pkg::M_IIX_L: dec_out.nptr = 2'h2;
            oag_pkg::M_IND_S, oag_pkg::M_IIX_S, oag_pkg::M_REL_I,
            oag_pkg::M_BIT_I, oag_pkg::M_BTJ_I: dec_out.nptr = 2'h1;
            default:                            dec_out.nptr = 2'h0;
        endcase
        if (dec_out.ill) begin
            dec_out.nopr = 2'h0;
            dec_out.nptr = 2'h0;
        end
        dec_out.len = {2'h0, pfx_valid_in} + 3'h1 + {1'b0, dec_out.nopr};
    end

endmodule // oag_mode_decode

// File: verilog/oag_pkg.sv
/*
 * Types of the operand address generator: addressing modes, sequencer
 * states and the decode and result carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package oag_pkg;

    typedef enum logic [4:0] {
        M_INH   = 5'b00000,
        M_IMM   = 5'b00001,
        M_DIR_S = 5'b00010,
        M_DIR_L = 5'b00011,
        M_IDX0  = 5'b00100,
        M_IDX_S = 5'b00101,
        M_IDX_L = 5'b00110,
        M_IND_S = 5'b00111,
        M_IND_L = 5'b01000,
        M_IIX_S = 5'b01001,
        M_IIX_L = 5'b01010,
        M_REL   = 5'b01011,
        M_REL_I = 5'b01100,
        M_BIT   = 5'b01101,
        M_BIT_I = 5'b01110,
        M_BTJ   = 5'b01111,
        M_BTJ_I = 5'b10000
    } oag_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD   = 2'b01,
        ST_CAP  = 2'b10,
        ST_CALC = 2'b11
    } oag_state_e;

    typedef struct packed {
        oag_mode_e   mode;
        logic        use_y;
        logic        ill;
        logic [1:0]  nopr;
        logic [1:0]  nptr;
        logic [2:0]  len;
    } oag_dec_s;

    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] tgt;
        logic [7:0]  opnd;
        logic [2:0]  len;
        oag_mode_e   mode;
        logic        err;
    } oag_res_s;

endpackage
